/* File: common/ncid_pkg.sv */
// Functional notes
// - Group from bits 15-11; 00111 extended
// - Data address is row field then column field
// - Low field gives immediate nibble or bit mask
// - Add, add-with-carry forms per opcode
// - Subtract forms to register or memory
// - Subtract-with-borrow forms use carry flag
// - AND and OR forms per opcode
// - Jump and call carry 11-bit in-page address
// - Page held as program counter bits 12-11
// - Segment bit supplies program counter bit 13
// - System entry target from bits 10-8, 3-0
// - Register file address: 3-bit row, 4-bit low field
// - Peripheral address: 3-bit high, 4-bit low
// - Interrupt acceptance pushes saved register automatically
// - Stack pointer selects active return stack entry
// - Jump opcodes 01100-01111 set page 0-3
package ncid_pkg;
	localparam int PC_W = 14;
	localparam int INPAGE_W = 11;
	localparam int RAS_DEPTH = 8;
	localparam int SP_W = 3;
	localparam int IST_DEPTH = 4;
	localparam int IST_W = 2;
	localparam int SAVED_W = 4;
	// Field positions in the instruction word
	localparam int OP_HI = 15;
	localparam int OP_LO = 11;
	localparam int ROW_HI = 10;
	localparam int ROW_LO = 8;
	localparam int COL_HI = 7;
	localparam int COL_LO = 4;
	localparam int LOW_HI = 3;
	localparam int LOW_LO = 0;
	localparam int SEG_BIT = 13;
	localparam int PAGE_HI = 12;
	localparam int PAGE_LO = 11;
	localparam logic [4:0] OP_EXT = 5'h07;
	localparam logic [4:0] OP_CALL = 5'h1c;
	localparam logic [2:0] OP_JUMP_PREFIX = 3'h3;
	localparam logic [2:0] ROW_ZERO = 3'h0;
	// Extended group selectors in the column field
	localparam logic [3:0] EXT_TABLE_READ = 4'h1;
	localparam logic [3:0] EXT_REGFILE_WRITE = 4'h2;
	localparam logic [3:0] EXT_REGFILE_READ = 4'h3;
	localparam logic [3:0] EXT_JUMP_ADDR_REG = 4'h4;
	localparam logic [3:0] EXT_SYSTEM_ENTRY = 4'h5;
	localparam logic [3:0] EXT_ROTATE = 4'h7;
	localparam logic [3:0] EXT_INC_INDEX = 4'h8;
	localparam logic [3:0] EXT_INC_ADDR_REG = 4'h9;
	localparam logic [3:0] EXT_IO_WRITE = 4'ha;
	localparam logic [3:0] EXT_IO_READ = 4'hb;
	localparam logic [3:0] EXT_POP = 4'hc;
	localparam logic [3:0] EXT_PUSH = 4'hd;
	localparam logic [PC_W-1:0] PC_RESET = 14'h0000;
	localparam logic [SP_W-1:0] SP_RESET = 3'h0;
	localparam logic [IST_W-1:0] IST_RESET = 2'h0;
	localparam logic [SP_W-1:0] SP_STEP = 3'h1;
	localparam logic [IST_W-1:0] IST_STEP = 2'h1;
	localparam logic [INPAGE_W-1:0] INPAGE_STEP = 11'h001;
	localparam logic [3:0] NIBBLE_ZERO = 4'h0;

	typedef enum logic [2:0] {
		NCID_ALU_ADD = 3'h0,
		NCID_ALU_SUB = 3'h1,
		NCID_ALU_AND = 3'h2,
		NCID_ALU_XOR = 3'h3,
		NCID_ALU_OR = 3'h4,
		NCID_ALU_ROT = 3'h5
	} ncid_alu_e;

	typedef struct packed {
		logic [4:0] opcode;
		logic ext;
		logic [3:0] ext_code;
		logic [6:0] data_addr;
		logic [3:0] immediate_nibble;
		logic [3:0] bit_mask;
		logic [6:0] regfile_addr;
		logic [6:0] io_unit_addr;
	} ncid_dec_s;

	typedef struct packed {
		logic reg_we;
		logic mem_we;
		logic [3:0] result;
	} ncid_wb_s;
endpackage : ncid_pkg

/* File: src/ncid_alu.sv */
`timescale 1ns/1ps
module ncid_alu (
	input wire ncid_pkg::ncid_alu_e op,
	input wire logic [3:0] a,
	input wire logic [3:0] b,
	input wire logic cin,
	output logic [3:0] y,
	output logic cout
);
	logic [4:0] sum;
	logic [4:0] diff;
	assign sum = {1'b0, a} + {1'b0, b} + {4'h0, cin};
	// Top bit of the difference is the borrow out
	assign diff = {1'b0, a} - {1'b0, b} - {4'h0, cin};
	always_comb
	begin
		y = a;
		cout = cin;
		case (op)
			ncid_pkg::NCID_ALU_ADD:
			begin
				y = sum[3:0];
				cout = sum[4];
			end
			ncid_pkg::NCID_ALU_SUB:
			begin
				y = diff[3:0];
				cout = diff[4];
			end
			ncid_pkg::NCID_ALU_AND: y = a & b;
			ncid_pkg::NCID_ALU_XOR: y = a ^ b;
			ncid_pkg::NCID_ALU_OR: y = a | b;
			ncid_pkg::NCID_ALU_ROT:
			begin
				y = {cin, a[3:1]};
				cout = a[0];
			end
			default:
			begin
				y = a;
				cout = cin;
			end
		endcase
	end
endmodule : ncid_alu

/* File: src/ncid_decode.sv */
`timescale 1ns/1ps
module ncid_decode (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [3:0] mem_nibble,
	input wire logic [3:0] gr_nibble,
	input wire logic [ncid_pkg::PC_W-1:0] address_register,
	input wire logic segment_wr,
	input wire logic segment_value,
	input wire logic irq_accept,
	input wire logic [ncid_pkg::SAVED_W-1:0] interrupt_saved_reg,
	output ncid_pkg::ncid_dec_s dec_q,
	output ncid_pkg::ncid_wb_s wb_q,
	output logic carry_flag,
	output logic [ncid_pkg::PC_W-1:0] pc_q,
	output logic segment_bit,
	output logic [ncid_pkg::SP_W-1:0] stack_pointer,
	output logic [ncid_pkg::PC_W-1:0] return_address_stack_top,
	output logic [ncid_pkg::IST_W-1:0] interrupt_stack_level,
	output logic [ncid_pkg::SAVED_W-1:0] interrupt_stack_top
);
	logic [4:0] opcode;
	logic [2:0] row_field;
	logic [3:0] col_field;
	logic [3:0] low_field;
	logic is_ext;
	logic is_jump;
	logic is_call;
	logic is_alu;
	logic is_rotate;
	logic is_jump_addr_reg;
	logic is_system_entry;
	logic use_immediate;
	logic carry_in_used;
	logic arith_op;
	logic [3:0] alu_a;
	logic [3:0] alu_b;
	logic [3:0] alu_y;
	logic alu_cout;
	logic alu_cin;
	ncid_pkg::ncid_alu_e alu_op;
	ncid_pkg::ncid_dec_s dec_next;
	ncid_pkg::ncid_wb_s wb_next;
	logic [ncid_pkg::INPAGE_W-1:0] inpage_inc;
	logic [ncid_pkg::PC_W-1:0] pc_advance;
	logic [ncid_pkg::PC_W-1:0] pc_next;
	logic [ncid_pkg::PC_W-1:0] entry_target;
	logic carry_next;
	logic [ncid_pkg::SP_W-1:0] sp_next;
	logic [ncid_pkg::IST_W-1:0] ist_next;
	logic [ncid_pkg::PC_W-1:0] ras_mem [ncid_pkg::RAS_DEPTH];
	logic [ncid_pkg::SAVED_W-1:0] ist_mem [ncid_pkg::IST_DEPTH];
	logic [ncid_pkg::SP_W-1:0] sp_push;
	logic [ncid_pkg::IST_W-1:0] ist_push;
	logic do_call;
	logic segment_now;

	// Field split; extended group selected by the 5-bit opcode
	assign opcode = instr_word[ncid_pkg::OP_HI:ncid_pkg::OP_LO];
	assign row_field = instr_word[ncid_pkg::ROW_HI:ncid_pkg::ROW_LO];
	assign col_field = instr_word[ncid_pkg::COL_HI:ncid_pkg::COL_LO];
	assign low_field = instr_word[ncid_pkg::LOW_HI:ncid_pkg::LOW_LO];
	assign is_ext = (opcode == ncid_pkg::OP_EXT);
	assign is_jump = (opcode[4:2] == ncid_pkg::OP_JUMP_PREFIX);
	assign is_call = (opcode == ncid_pkg::OP_CALL);
	assign is_rotate = is_ext && (row_field == ncid_pkg::ROW_ZERO)
		&& (col_field == ncid_pkg::EXT_ROTATE);
	assign is_jump_addr_reg = is_ext && (row_field == ncid_pkg::ROW_ZERO)
		&& (col_field == ncid_pkg::EXT_JUMP_ADDR_REG);
	assign is_system_entry = is_ext && (col_field == ncid_pkg::EXT_SYSTEM_ENTRY);

	// Opcodes x0000..x0110 are the nibble arithmetic and logic group
	assign is_alu = (opcode[3] == 1'b0) && (opcode[2:0] != 3'h7);
	assign use_immediate = opcode[4];
	assign arith_op = is_alu && (opcode[2] == 1'b0);
	assign carry_in_used = arith_op && opcode[1];
	assign alu_op = is_rotate ? ncid_pkg::NCID_ALU_ROT
		: (opcode[2:0] == 3'h4) ? ncid_pkg::NCID_ALU_AND
		: (opcode[2:0] == 3'h5) ? ncid_pkg::NCID_ALU_XOR
		: (opcode[2:0] == 3'h6) ? ncid_pkg::NCID_ALU_OR
		: opcode[0] ? ncid_pkg::NCID_ALU_SUB : ncid_pkg::NCID_ALU_ADD;
	// Register form: (r) op (m); memory form: (m) op immediate
	assign alu_a = (use_immediate && !is_rotate) ? mem_nibble : gr_nibble;
	assign alu_b = use_immediate ? low_field : mem_nibble;
	// Rotate shifts the carry in, so it always sees the flag
	assign alu_cin = (carry_in_used || is_rotate) ? carry_flag : 1'b0;

	ncid_alu u_alu (
		.op(alu_op),
		.a(alu_a),
		.b(alu_b),
		.cin(alu_cin),
		.y(alu_y),
		.cout(alu_cout)
	);

	always_comb
	begin
		dec_next.opcode = opcode;
		dec_next.ext = is_ext;
		dec_next.ext_code = col_field;
		dec_next.data_addr = {row_field, col_field};
		dec_next.immediate_nibble = low_field;
		dec_next.bit_mask = low_field;
		dec_next.regfile_addr = {row_field, low_field};
		dec_next.io_unit_addr = {row_field, low_field};
	end

	assign wb_next.reg_we = instr_valid && ((is_alu && !use_immediate) || is_rotate);
	assign wb_next.mem_we = instr_valid && is_alu && use_immediate;
	assign wb_next.result = alu_y;

	// Borrow counts as carry so multi-nibble chains work
	assign carry_next = (instr_valid && (arith_op || is_rotate)) ? alu_cout : carry_flag;

	assign segment_now = segment_wr ? segment_value : segment_bit;
	assign inpage_inc = pc_q[ncid_pkg::INPAGE_W-1:0] + ncid_pkg::INPAGE_STEP;
	// Sequential fetch wraps inside the page, page bits untouched
	assign pc_advance = {segment_now, pc_q[ncid_pkg::PAGE_HI:ncid_pkg::PAGE_LO],
		inpage_inc};
	assign entry_target = {segment_now, 2'h0, row_field, 4'h0, low_field};

	always_comb
	begin
		pc_next = {segment_now, pc_q[ncid_pkg::PC_W-2:0]};
		if (instr_valid)
		begin
			if (is_jump)
				pc_next = {segment_now, opcode[1:0],
					instr_word[ncid_pkg::INPAGE_W-1:0]};
			else if (is_call)
				pc_next = {segment_now, 2'h0,
					instr_word[ncid_pkg::INPAGE_W-1:0]};
			else if (is_jump_addr_reg)
				pc_next = {segment_now, address_register[ncid_pkg::PC_W-2:0]};
			else if (is_system_entry)
				pc_next = entry_target;
			else
				pc_next = pc_advance;
		end
	end

	// Return stack grows downward; pointer names the live entry
	assign do_call = instr_valid && is_call;
	assign sp_push = stack_pointer - ncid_pkg::SP_STEP;
	assign sp_next = do_call ? sp_push : stack_pointer;
	assign ist_push = interrupt_stack_level + ncid_pkg::IST_STEP;
	// No overflow guard: deeper nesting overwrites the oldest slot
	assign ist_next = irq_accept ? ist_push : interrupt_stack_level;

	always_ff @(posedge sys_clk)
	begin
		if (do_call)
			ras_mem[sp_push] <= pc_advance;
		if (irq_accept)
			ist_mem[ist_push] <= interrupt_saved_reg;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			pc_q <= ncid_pkg::PC_RESET;
			segment_bit <= 1'b0;
			carry_flag <= 1'b0;
			stack_pointer <= ncid_pkg::SP_RESET;
			interrupt_stack_level <= ncid_pkg::IST_RESET;
		end
		else
		begin
			pc_q <= pc_next;
			segment_bit <= segment_now;
			carry_flag <= carry_next;
			stack_pointer <= sp_next;
			interrupt_stack_level <= ist_next;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			dec_q <= '0;
			wb_q <= '0;
			return_address_stack_top <= ncid_pkg::PC_RESET;
			interrupt_stack_top <= ncid_pkg::NIBBLE_ZERO;
		end
		else
		begin
			dec_q <= instr_valid ? dec_next : dec_q;
			wb_q <= wb_next;
			return_address_stack_top <= do_call ? pc_advance : ras_mem[sp_next];
			interrupt_stack_top <= irq_accept ? interrupt_saved_reg : ist_mem[ist_next];
		end
	end
endmodule : ncid_decode

/* File: tb/ncid_decode_assertions.sv */
`timescale 1ns/1ps
module ncid_decode_assertions (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [3:0] mem_nibble,
	input wire logic [3:0] gr_nibble,
	input wire logic segment_wr,
	input wire logic irq_accept,
	input wire logic [3:0] interrupt_saved_reg,
	input wire ncid_pkg::ncid_dec_s dec_q,
	input wire ncid_pkg::ncid_wb_s wb_q,
	input wire logic carry_flag,
	input wire logic [13:0] pc_q,
	input wire logic segment_bit,
	input wire logic [2:0] stack_pointer,
	input wire logic [13:0] return_address_stack_top,
	input wire logic [1:0] interrupt_stack_level,
	input wire logic [3:0] interrupt_stack_top
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Valid bit glued to opcode keeps the antecedents short
	wire logic [5:0] vop = {instr_valid, instr_word[15:11]};
	a_ext_group: assert property (instr_valid |=> dec_q.ext == ($past(vop) == 6'h27))
		else $error("extended group flag wrong");
	a_data_addr: assert property (instr_valid |=> dec_q.data_addr == $past(instr_word[10:4]))
		else $error("data address wrong");
	a_low_field: assert property (instr_valid |=> dec_q.immediate_nibble == $past(instr_word[3:0])
		&& dec_q.bit_mask == $past(instr_word[3:0]))
		else $error("low field wrong");
	a_rf_io_addr: assert property (instr_valid |=> dec_q.io_unit_addr == dec_q.regfile_addr
		&& dec_q.regfile_addr == {$past(instr_word[10:8]), $past(instr_word[3:0])})
		else $error("register file or unit address wrong");
	a_add_reg: assert property (vop == 6'h20 |=> wb_q.reg_we
		&& wb_q.result == $past(gr_nibble + mem_nibble))
		else $error("add to register wrong");
	a_sub_mem: assert property (vop == 6'h31 |=> wb_q.mem_we
		&& wb_q.result == $past(mem_nibble - instr_word[3:0]))
		else $error("subtract from memory wrong");
	a_subtract_with_borrow_reg: assert property (vop == 6'h23 |=> wb_q.reg_we
		&& wb_q.result == $past(gr_nibble - mem_nibble - carry_flag))
		else $error("subtract with borrow wrong");
	a_or_mem: assert property (vop == 6'h36 |=> wb_q.mem_we
		&& wb_q.result == $past(mem_nibble | instr_word[3:0]))
		else $error("or into memory wrong");
	a_jump_page: assert property (instr_valid && instr_word[15:13] == 3'h3
		|=> pc_q[12:0] == $past(instr_word[12:0]))
		else $error("jump target or page wrong");
	a_segment_pc: assert property (pc_q[13] == segment_bit)
		else $error("segment bit not in program counter");
	a_entry_target: assert property (vop == 6'h27 && instr_word[7:4] == 4'h5 |=> pc_q[12:0]
		== {2'h0, $past(instr_word[10:8]), 4'h0, $past(instr_word[3:0])})
		else $error("system entry target wrong");
	a_call_push: assert property (vop == 6'h3c && !segment_wr |=> stack_pointer
		== $past(stack_pointer) - 3'h1 && return_address_stack_top
		== {$past(pc_q[13:11]), $past(pc_q[10:0]) + 11'h001})
		else $error("call push wrong");
	a_irq_push: assert property (irq_accept |=> interrupt_stack_top == $past(interrupt_saved_reg)
		&& interrupt_stack_level == $past(interrupt_stack_level) + 2'h1)
		else $error("interrupt push wrong");
	a_add_carry: assert property (vop == 6'h20 |=> carry_flag
		== ($past({1'b0, gr_nibble} + {1'b0, mem_nibble}) > 5'h0f))
		else $error("add carry wrong");
	cover property (vop == 6'h3c);
	cover property (irq_accept);
	cover property (vop == 6'h27 && instr_word[7:4] == 4'h5);
endmodule : ncid_decode_assertions
bind ncid_decode ncid_decode_assertions i_chk (.*);

/* File: tb/ncid_prog_mem.sv */
`timescale 1ns/1ps
module ncid_prog_mem (
	input wire logic [3:0] fetch_addr,
	output logic [15:0] instr_word
);
	// Only a 16-word window; the bench writes the word at the fetch slot
	logic [15:0] rom [16];
	assign instr_word = rom[fetch_addr];
endmodule : ncid_prog_mem

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic instr_valid = 1'b0;
	logic segment_wr = 1'b0;
	logic segment_value = 1'b0;
	logic irq_accept = 1'b0;
	logic [3:0] mem_nibble = 4'h0;
	logic [3:0] gr_nibble = 4'h0;
	logic [3:0] interrupt_saved_reg = 4'h0;
	logic [13:0] address_register = 14'h0000;
	wire logic [15:0] instr_word;
	ncid_pkg::ncid_dec_s dec_q;
	ncid_pkg::ncid_wb_s wb_q;
	logic carry_flag;
	logic segment_bit;
	logic [13:0] pc_q;
	logic [13:0] ras_top;
	logic [2:0] stack_pointer;
	logic [1:0] ist_lvl;
	logic [3:0] ist_top;
	int n_mismatch = 0;
	int samples_checked = 0;
	logic [4:0] ops [14] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
		5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16};
	logic carry_exp = 1'b0;
	logic seg = 1'b0;
	logic [1:0] lvl = 2'h0;
	logic [2:0] sp = 3'h0;
	logic [13:0] old_pc;
	logic [15:0] w;
	logic [4:0] r;
	logic [4:0] e;
	always #12.5 sys_clk = ~sys_clk;
	ncid_prog_mem i_mem (.fetch_addr(pc_q[3:0]), .instr_word(instr_word));
	ncid_decode i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .instr_valid(instr_valid),
		.instr_word(instr_word), .mem_nibble(mem_nibble), .gr_nibble(gr_nibble),
		.address_register(address_register), .segment_wr(segment_wr),
		.segment_value(segment_value), .irq_accept(irq_accept),
		.interrupt_saved_reg(interrupt_saved_reg), .dec_q(dec_q), .wb_q(wb_q),
		.carry_flag(carry_flag), .pc_q(pc_q), .segment_bit(segment_bit),
		.stack_pointer(stack_pointer), .return_address_stack_top(ras_top),
		.interrupt_stack_level(ist_lvl), .interrupt_stack_top(ist_top));
	function automatic logic [4:0] alu(input logic [4:0] op, input logic [3:0] a,
		input logic [3:0] b, input logic c);
		logic ci;
		ci = op[1] & c;
		case (op[2:0])
			3'h0, 3'h2: return {1'b0, a} + {1'b0, b} + 5'(ci);
			3'h1, 3'h3: return {1'b0, a} - {1'b0, b} - 5'(ci);
			3'h4: return {c, a & b};
			3'h5: return {c, a ^ b};
			default: return {c, a | b};
		endcase
	endfunction : alu
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Side inputs stay quiet on calls: a segment load there makes the return value ambiguous
	task automatic step(input logic [15:0] word, input logic side);
		i_mem.rom[pc_q[3:0]] = word;
		instr_valid = 1'b1;
		mem_nibble = 4'($urandom);
		gr_nibble = 4'($urandom);
		address_register = 14'($urandom);
		interrupt_saved_reg = 4'($urandom);
		irq_accept = side & 1'($urandom);
		segment_wr = side && $urandom_range(0, 7) == 0;
		segment_value = 1'($urandom);
		@(posedge sys_clk);
		#1;
		if (segment_wr)
			seg = segment_value;
		if (irq_accept)
			lvl = lvl + 2'h1;
		chk({segment_bit, pc_q[13]}, {2{seg}});
		if (irq_accept)
			chk({ist_lvl, ist_top}, {lvl, interrupt_saved_reg});
		chk(dec_q.data_addr, word[10:4]);
		chk({dec_q.immediate_nibble, dec_q.bit_mask}, {2{word[3:0]}});
		chk(dec_q.regfile_addr, {word[10:8], word[3:0]});
		chk(dec_q.io_unit_addr, {word[10:8], word[3:0]});
		chk(dec_q.ext, word[15:11] == 5'h07);
		chk({dec_q.opcode, dec_q.ext_code}, {word[15:11], word[7:4]});
	endtask : step
	task automatic final_report();
		$display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	initial
	begin
		#200000;
		n_mismatch++;
		final_report();
	end
	initial
	begin
		void'($urandom(5));
		repeat (6) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		for (int p = 0; p < 4; p++)
		begin
			w = {3'h3, 2'(p), 11'($urandom)};
			step(w, 1'b1);
			chk(pc_q, {seg, w[12:0]});
		end
		repeat (2)
		begin
			old_pc = pc_q;
			w = {5'h1c, 11'($urandom)};
			step(w, 1'b0);
			sp = sp - 3'h1;
			chk(pc_q, {seg, 2'h0, w[10:0]});
			chk({stack_pointer, ras_top}, {sp, old_pc[13:11], old_pc[10:0] + 11'h001});
		end
		w = {5'h07, 3'($urandom), 4'h5, 4'($urandom)};
		step(w, 1'b1);
		chk(pc_q, {seg, 2'h0, w[10:8], 4'h0, w[3:0]});
		// Register jump keeps the segment bit, whatever the register's top bit
		w = {5'h07, 3'h0, 4'h4, 4'($urandom)};
		step(w, 1'b1);
		chk(pc_q, {seg, address_register[12:0]});
		w = {5'h07, 3'h0, 4'h7, 4'($urandom)};
		step(w, 1'b1);
		chk({wb_q.result, wb_q.reg_we, wb_q.mem_we}, {carry_exp, gr_nibble[3:1], 2'h2});
		chk(carry_flag, gr_nibble[0]);
		carry_exp = gr_nibble[0];
		repeat (200)
		begin
			r = ops[$urandom_range(0, 13)];
			w = {r, 11'($urandom)};
			old_pc = pc_q;
			step(w, 1'b1);
			e = alu(r, r[4] ? mem_nibble : gr_nibble, r[4] ? w[3:0] : mem_nibble, carry_exp);
			chk(wb_q.result, e[3:0]);
			chk({wb_q.reg_we, wb_q.mem_we}, {~r[4], r[4]});
			chk(carry_flag, e[4]);
			chk(pc_q, {seg, old_pc[12:11], old_pc[10:0] + 11'h001});
			carry_exp = e[4];
		end
		instr_valid = 1'b0;
		final_report();
	end
endmodule : tb_top
